//--- rtl/legacy_address_decoder.sv
// legacy address decoder: compatibility-area routing and above-4GB termination
// Notes on behaviour
// RULE1 - claim above-4GB accesses, drop their data
// RULE2 - terminated reads return all zeros
// RULE3 - no downstream address beyond 32 bits
// RULE4 - software keeps programmable ranges non-overlapping
// RULE5 - decode memory to 4GB, no remap
// RULE6 - low 640KB always goes to DRAM
// RULE7 - thirteen segments: separate read, write enables
// RULE8 - expansion segments: read, write, both, none
// RULE9 - BIOS extension segments routed by own attributes
// RULE10 - disabled segment DRAM is never relocated
// RULE11 - system BIOS segment resets fully disabled
// RULE12 - enabled BIOS attributes shadow into DRAM
// RULE13 - video range steered by vga and mono bits
// RULE14 - graphics port claimed first in video range
// RULE15 - SMM processor video accesses hit DRAM
// RULE16 - downstream SMM-space cycles treated as video
// RULE17 - mono memory range steered to gfx or hub
// RULE18 - mono adapter I/O ports steered likewise
// RULE19 - video range is default SMM space
// RULE20 - enabled direction to DRAM, else hub
`timescale 1ns/1ps
`default_nettype none

module legacy_address_decoder
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic [legacy_address_decoder_pkg::REG_ADDR_W-1:0] i_reg_addr,
   input wire logic [legacy_address_decoder_pkg::DATA_W-1:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [legacy_address_decoder_pkg::DATA_W-1:0] o_reg_rdata,
   input wire legacy_address_decoder_pkg::request_s i_req,
   output legacy_address_decoder_pkg::forward_s o_fwd,
   output legacy_address_decoder_pkg::host_reply_s o_host_reply
);

   typedef struct packed {
      logic vga_en;
      logic mono_present;
      logic smm_en;
      logic [legacy_address_decoder_pkg::ATTR_W-1:0] seg_attr;
      logic [legacy_address_decoder_pkg::COUNT_W-1:0] term_count;
      legacy_address_decoder_pkg::target_e last_target;
      logic [legacy_address_decoder_pkg::DATA_W-1:0] rdata;
      legacy_address_decoder_pkg::forward_s fwd;
      legacy_address_decoder_pkg::host_reply_s reply;
   } state_s;

   state_s state_q;
   state_s state_d;

   logic [legacy_address_decoder_pkg::NUM_SEGS-1:0] seg_hit;
   logic [legacy_address_decoder_pkg::NUM_SEGS-1:0] seg_rd_en;
   logic [legacy_address_decoder_pkg::NUM_SEGS-1:0] seg_wr_en;
   logic [19:0] low_addr;
   logic above_4g;
   logic below_1m;
   logic in_dos;
   logic in_video;
   logic in_mono;
   logic in_attr;
   logic mono_io;
   logic seg_to_dram;
   logic smm_dram;
   legacy_address_decoder_pkg::target_e video_target;
   legacy_address_decoder_pkg::target_e route;

   assign low_addr = i_req.addr[19:0];
   assign above_4g = |i_req.addr[legacy_address_decoder_pkg::HOST_ADDR_W-1:32];
   assign below_1m = ~|i_req.addr[31:20];
   // the segment compares below rely on the region bases being ordered
   assign in_dos = below_1m && (low_addr < legacy_address_decoder_pkg::VIDEO_BASE);
   assign in_video = below_1m && (low_addr >= legacy_address_decoder_pkg::VIDEO_BASE)
      && (low_addr < legacy_address_decoder_pkg::EXP_BASE);
   assign in_mono = in_video && (low_addr[19:15] == legacy_address_decoder_pkg::MONO_PAGE);
   assign in_attr = below_1m && (low_addr >= legacy_address_decoder_pkg::EXP_BASE);

   // thirteen segments, twelve of 16KB and one 64KB BIOS segment, each with its own attribute pair
   genvar g;
   generate
      for (g = 0; g < legacy_address_decoder_pkg::NUM_SEGS; g++)
      begin : g_seg
         if (g < legacy_address_decoder_pkg::NUM_SMALL_SEGS)
         begin : g_small
            // RULE8 sixteen-KB segments
            assign seg_hit[g] = in_attr && (low_addr[19:14]
               == legacy_address_decoder_pkg::SMALL_SEG_FIRST + 6'(g));
         end
         else
         begin : g_bios
            // RULE12 single 64KB segment
            assign seg_hit[g] = in_attr
               && (low_addr >= legacy_address_decoder_pkg::BIOS_BASE);
         end
         // RULE7 separate enables
         assign seg_rd_en[g] = state_q.seg_attr[2*g + legacy_address_decoder_pkg::POS_RD_EN];
         assign seg_wr_en[g] = state_q.seg_attr[2*g + legacy_address_decoder_pkg::POS_WR_EN];
      end
   endgenerate

   // RULE20 direction picks the enable
   // RULE9 per-segment routing
   assign seg_to_dram = i_req.is_write ? |(seg_hit & seg_wr_en) : |(seg_hit & seg_rd_en);

   // RULE18 mono I/O ports
   assign mono_io = (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3B4)
      || (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3B5)
      || (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3B8)
      || (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3B9)
      || (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3BA)
      || (i_req.addr[15:0] == legacy_address_decoder_pkg::MONO_IO_3BF);

   // RULE15 SMM processor to DRAM
   // RULE16 downstream never reaches SMM DRAM
   // RULE19 video range as SMM space
   assign smm_dram = state_q.smm_en && i_req.smm
      && (i_req.origin == legacy_address_decoder_pkg::ORG_CPU);

   // a present mono adapter lives on the hub; the rest of video follows vga enable
   always_comb
   begin
      video_target = legacy_address_decoder_pkg::TGT_HUB;
      // RULE14 graphics claimed first
      if (state_q.vga_en)
      begin
         video_target = legacy_address_decoder_pkg::TGT_GFX;
      end
      // RULE13 video steering
      // RULE17 mono range steering
      if ((in_mono || (i_req.is_io && mono_io)) && state_q.mono_present)
      begin
         video_target = legacy_address_decoder_pkg::TGT_HUB;
      end
   end

   always_comb
   begin
      route = legacy_address_decoder_pkg::TGT_HUB;
      if (i_req.is_io)
      begin
         route = mono_io ? video_target : legacy_address_decoder_pkg::TGT_HUB;
      end
      else if (above_4g)
      begin
         // RULE1 claim above 4GB
         route = legacy_address_decoder_pkg::TGT_TERM;
      end
      else if (in_dos)
      begin
         // RULE6 fixed DRAM
         route = legacy_address_decoder_pkg::TGT_DRAM;
      end
      else if (in_video)
      begin
         route = smm_dram ? legacy_address_decoder_pkg::TGT_DRAM : video_target;
      end
      else if (in_attr)
      begin
         // RULE10 disabled goes to hub, never remapped
         route = seg_to_dram ? legacy_address_decoder_pkg::TGT_DRAM
            : legacy_address_decoder_pkg::TGT_HUB;
      end
      else
      begin
         // RULE5 flat decode up to 4GB
         route = legacy_address_decoder_pkg::TGT_DRAM;
      end
   end

   always_comb
   begin
      state_d = state_q;
      state_d.fwd.valid = 1'b0;
      state_d.reply.valid = 1'b0;
      state_d.rdata = '0;

      if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            legacy_address_decoder_pkg::OFS_VIDEO_CTRL:
            begin
               state_d.vga_en = i_reg_wdata[legacy_address_decoder_pkg::POS_VGA_EN];
               state_d.mono_present =
                  i_reg_wdata[legacy_address_decoder_pkg::POS_MONO_PRESENT];
               state_d.smm_en = i_reg_wdata[legacy_address_decoder_pkg::POS_SMM_EN];
            end
            legacy_address_decoder_pkg::OFS_SEG_ATTR:
            begin
               state_d.seg_attr = i_reg_wdata[legacy_address_decoder_pkg::ATTR_W-1:0];
            end
            default:
            begin
               state_d.seg_attr = state_q.seg_attr;
            end
         endcase
      end

      if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            legacy_address_decoder_pkg::OFS_VIDEO_CTRL:
            begin
               state_d.rdata[legacy_address_decoder_pkg::POS_VGA_EN] = state_q.vga_en;
               state_d.rdata[legacy_address_decoder_pkg::POS_MONO_PRESENT] =
                  state_q.mono_present;
               state_d.rdata[legacy_address_decoder_pkg::POS_SMM_EN] = state_q.smm_en;
            end
            legacy_address_decoder_pkg::OFS_SEG_ATTR:
            begin
               state_d.rdata[legacy_address_decoder_pkg::ATTR_W-1:0] = state_q.seg_attr;
            end
            legacy_address_decoder_pkg::OFS_STATUS:
            begin
               state_d.rdata[legacy_address_decoder_pkg::POS_TERM_COUNT +: 16] =
                  state_q.term_count;
               state_d.rdata[legacy_address_decoder_pkg::POS_LAST_TARGET +: 2] =
                  state_q.last_target;
            end
            default:
            begin
               // unmapped addresses read as zero
               state_d.rdata = '0;
            end
         endcase
      end

      if (i_req.valid)
      begin
         state_d.last_target = route;
         if (route == legacy_address_decoder_pkg::TGT_TERM)
         begin
            // counter saturates so software can tell a flood from a wrap
            if (state_q.term_count != 16'hFFFF)
            begin
               state_d.term_count = state_q.term_count + 16'h0001;
            end
            // RULE2 zero data on reads
            if (!i_req.is_write)
            begin
               state_d.reply.valid = 1'b1;
               state_d.reply.data = '0;
            end
         end
         else
         begin
            state_d.fwd.valid = 1'b1;
            state_d.fwd.target = route;
            // RULE3 only 32-bit addresses leave
            state_d.fwd.addr = i_req.addr[legacy_address_decoder_pkg::DOWN_ADDR_W-1:0];
            state_d.fwd.is_io = i_req.is_io;
            state_d.fwd.is_write = i_req.is_write;
            state_d.fwd.wdata = i_req.wdata;
         end
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q.vga_en <= legacy_address_decoder_pkg::RST_VGA_EN;
         state_q.mono_present <= legacy_address_decoder_pkg::RST_MONO_PRESENT;
         state_q.smm_en <= legacy_address_decoder_pkg::RST_SMM_EN;
         // RULE11 BIOS segment disabled at reset
         state_q.seg_attr <= legacy_address_decoder_pkg::RST_SEG_ATTR;
         state_q.term_count <= legacy_address_decoder_pkg::RST_TERM_COUNT;
         state_q.last_target <= legacy_address_decoder_pkg::TGT_DRAM;
         state_q.rdata <= '0;
         state_q.fwd <= '0;
         state_q.reply <= '0;
      end
      else if (i_clk_en)
      begin
         state_q <= state_d;
      end
   end

   assign o_reg_rdata = state_q.rdata;
   assign o_fwd = state_q.fwd;
   assign o_host_reply = state_q.reply;

endmodule // legacy_address_decoder

`default_nettype wire

//--- rtl/legacy_address_decoder_pkg.sv
// constants and carrier types of the legacy address decoder
package legacy_address_decoder_pkg;
   localparam int unsigned REG_ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned HOST_ADDR_W = 36;
   localparam int unsigned DOWN_ADDR_W = 32;
   localparam int unsigned HOST_DATA_W = 64;
   localparam int unsigned NUM_SEGS = 13;
   localparam int unsigned NUM_SMALL_SEGS = 12;
   localparam int unsigned ATTR_W = 2 * NUM_SEGS;
   localparam int unsigned COUNT_W = 16;

   // register byte addresses
   localparam logic [REG_ADDR_W-1:0] OFS_VIDEO_CTRL = 4'h0;
   localparam logic [REG_ADDR_W-1:0] OFS_SEG_ATTR = 4'h4;
   localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 4'h8;

   // video control fields
   localparam int unsigned POS_VGA_EN = 0;
   localparam int unsigned POS_MONO_PRESENT = 1;
   localparam int unsigned POS_SMM_EN = 2;
   // segment attribute fields: segment i uses bits 2i (read) and 2i+1 (write)
   localparam int unsigned POS_RD_EN = 0;
   localparam int unsigned POS_WR_EN = 1;
   // status fields
   localparam int unsigned POS_TERM_COUNT = 0;
   localparam int unsigned POS_LAST_TARGET = 16;

   localparam logic RST_VGA_EN = 1'h0;
   localparam logic RST_MONO_PRESENT = 1'h0;
   localparam logic RST_SMM_EN = 1'h0;
   localparam logic [ATTR_W-1:0] RST_SEG_ATTR = 26'h0000000;
   localparam logic [COUNT_W-1:0] RST_TERM_COUNT = 16'h0000;

   // address map: region bases as byte addresses, MONO_PAGE in bits [19:15], SMALL_SEG_FIRST in bits [19:14] (16 KB), then the mono I/O ports
   localparam logic [19:0] VIDEO_BASE = 20'hA0000;
   localparam logic [19:0] EXP_BASE = 20'hC0000;
   localparam logic [19:0] BIOS_BASE = 20'hF0000;
   localparam logic [19:15] MONO_PAGE = 5'h16;
   localparam logic [5:0] SMALL_SEG_FIRST = 6'h30;
   localparam logic [15:0] MONO_IO_3B4 = 16'h03B4;
   localparam logic [15:0] MONO_IO_3B5 = 16'h03B5;
   localparam logic [15:0] MONO_IO_3B8 = 16'h03B8;
   localparam logic [15:0] MONO_IO_3B9 = 16'h03B9;
   localparam logic [15:0] MONO_IO_3BA = 16'h03BA;
   localparam logic [15:0] MONO_IO_3BF = 16'h03BF;

   typedef enum logic [1:0] {
      TGT_DRAM = 2'h0,
      TGT_GFX = 2'h1,
      TGT_HUB = 2'h3,
      TGT_TERM = 2'h2
   } target_e;

   typedef enum logic [1:0] {
      ORG_CPU = 2'h0,
      ORG_GFX = 2'h1,
      ORG_HUB = 2'h2
   } origin_e;

   typedef struct packed {
      logic valid;
      logic [HOST_ADDR_W-1:0] addr;
      logic is_io;
      logic is_write;
      logic smm;
      origin_e origin;
      logic [HOST_DATA_W-1:0] wdata;
   } request_s;

   typedef struct packed {
      logic valid;
      target_e target;
      logic [DOWN_ADDR_W-1:0] addr;
      logic is_io;
      logic is_write;
      logic [HOST_DATA_W-1:0] wdata;
   } forward_s;

   typedef struct packed {
      logic valid;
      logic [HOST_DATA_W-1:0] data;
   } host_reply_s;
endpackage

//--- test/legacy_address_decoder_assertions.sv
// concurrent checks on the legacy address decoder ports
`timescale 1ns/1ps
`default_nettype none
module legacy_address_decoder_assertions
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic [3:0] i_reg_addr,
   input wire logic [31:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [31:0] o_reg_rdata,
   input wire legacy_address_decoder_pkg::request_s i_req,
   input wire legacy_address_decoder_pkg::forward_s o_fwd,
   input wire legacy_address_decoder_pkg::host_reply_s o_host_reply
);
   `include "legacy_route_ref.svh"
   logic [2:0] vctl_q;
   logic [25:0] attr_q;
   logic [1:0] exp_t;
   logic video;
   logic smm_hit;
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         vctl_q <= 3'h0;
         attr_q <= 26'h0;
      end
      else if (i_clk_en && i_reg_wr && i_reg_addr == 4'h0)
         vctl_q <= i_reg_wdata[2:0];
      else if (i_clk_en && i_reg_wr && i_reg_addr == 4'h4)
         attr_q <= i_reg_wdata[25:0];
   end
   always_comb exp_t = route_ref(i_req, vctl_q, attr_q);
   assign video = !i_req.is_io && i_req.addr[35:17] == 19'h5;
   assign smm_hit = vctl_q[2] && i_req.smm && i_req.origin == 2'h0;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   sequence s_req;
      i_clk_en && i_req.valid;
   endsequence
   sequence s_high;
      s_req ##0 (!i_req.is_io && i_req.addr[35:32] != 4'h0);
   endsequence
   sequence s_as_ref;
      o_fwd.valid && o_fwd.target == $past(exp_t);
   endsequence
   property p_term_read;
      s_high ##0 !i_req.is_write |=> o_host_reply.valid && o_host_reply.data == 64'h0 && !o_fwd.valid;
   endproperty
   a_term_read: assert property (p_term_read)
      else $error("terminated read wrong");
   property p_term_write;
      s_high ##0 i_req.is_write |=> !o_fwd.valid && !o_host_reply.valid;
   endproperty
   a_term_write: assert property (p_term_write)
      else $error("terminated write leaked");
   property p_narrow;
      $past(i_clk_en) && o_fwd.valid |-> $past(i_req.addr[35:32]) == 4'h0 || $past(i_req.is_io);
   endproperty
   a_narrow: assert property (p_narrow)
      else $error("wide address forwarded");
   property p_low;
      s_req ##0 (!i_req.is_io && i_req.addr < 36'hA0000) |=>
         o_fwd.valid && o_fwd.target == 2'h0 && o_fwd.addr == $past(i_req.addr[31:0]);
   endproperty
   a_low: assert property (p_low)
      else $error("low area not to dram");
   property p_ext;
      s_req ##0 (!i_req.is_io && i_req.addr[35:32] == 4'h0 && i_req.addr[31:20] != 12'h0) |=>
         o_fwd.valid && o_fwd.target == 2'h0;
   endproperty
   a_ext: assert property (p_ext)
      else $error("extended memory not to dram");
   property p_seg;
      s_req ##0 (!i_req.is_io && i_req.addr[35:18] == 18'h3) |=> s_as_ref;
   endproperty
   a_seg: assert property (p_seg)
      else $error("segment routing wrong");
   property p_video;
      s_req ##0 (video && !smm_hit) |=> s_as_ref;
   endproperty
   a_video: assert property (p_video)
      else $error("video routing wrong");
   property p_smm;
      s_req ##0 (video && smm_hit) |=> o_fwd.valid && o_fwd.target == 2'h0;
   endproperty
   a_smm: assert property (p_smm)
      else $error("smm access not to dram");
   property p_smm_down;
      s_req ##0 (video && i_req.origin != 2'h0) |=> o_fwd.valid && o_fwd.target != 2'h0;
   endproperty
   a_smm_down: assert property (p_smm_down)
      else $error("downstream cycle reached dram");
   property p_io;
      s_req ##0 i_req.is_io |=> s_as_ref;
   endproperty
   a_io: assert property (p_io)
      else $error("io routing wrong");
endmodule // legacy_address_decoder_assertions
bind legacy_address_decoder legacy_address_decoder_assertions u_assertions (.i_clock(i_clock),
   .i_rst(i_rst), .i_clk_en(i_clk_en), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
   .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_req(i_req),
   .o_fwd(o_fwd), .o_host_reply(o_host_reply));
`default_nettype wire

//--- test/legacy_downstream_sink.sv
// far-side model: dram, graphics and hub ports taking forwarded cycles
`timescale 1ns/1ps
`default_nettype none
module legacy_downstream_sink
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire legacy_address_decoder_pkg::forward_s i_fwd,
   output logic [31:0] o_taken,
   output logic [31:0] o_dram_taken
);
   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_taken <= 32'h0;
         o_dram_taken <= 32'h0;
      end
      else if (i_fwd.valid)
      begin
         o_taken <= o_taken + 32'h1;
         o_dram_taken <= o_dram_taken + {31'h0, i_fwd.target == 2'h0};
      end
   end
endmodule // legacy_downstream_sink
`default_nettype wire

//--- test/legacy_route_ref.svh
// reference routing: 0 dram, 1 graphics, 2 terminated, 3 hub
// no include guard: the bench and the checker each need their own copy in scope
function automatic logic [1:0] route_ref(input legacy_address_decoder_pkg::request_s r,
   input logic [2:0] v, input logic [25:0] a);
   logic [5:0] s;
   logic mono;
   s = (r.addr[19:14] > 6'h3C) ? 6'hC : r.addr[19:14] - 6'h30;
   mono = r.is_io ? (r.addr[15:0] inside {16'h3B4, 16'h3B5, 16'h3B8, 16'h3B9, 16'h3BA, 16'h3BF})
      : (r.addr[19:15] == 5'h16);
   if (r.is_io)
      return (mono && v[0] && !v[1]) ? 2'h1 : 2'h3;
   if (r.addr[35:32] != 4'h0)
      return 2'h2;
   if (r.addr[31:20] != 12'h0 || r.addr[19:0] < 20'hA0000)
      return 2'h0;
   // a disabled direction never falls back to dram
   if (r.addr[19:0] >= 20'hC0000)
      return a[2 * s + r.is_write] ? 2'h0 : 2'h3;
   if (v[2] && r.smm && r.origin == legacy_address_decoder_pkg::ORG_CPU)
      return 2'h0;
   return ((mono && v[1]) || !v[0]) ? 2'h3 : 2'h1;
endfunction

//--- test/test_legacy_address_decoder.sv
// self-checking bench of the legacy address decoder
`timescale 1ns/1ps
`default_nettype none
module test_legacy_address_decoder;
   `include "legacy_route_ref.svh"
   logic i_clock = 1'b0;
   logic i_rst = 1'b1;
   logic i_clk_en = 1'b1;
   logic [3:0] i_reg_addr = 4'h0;
   logic [31:0] i_reg_wdata = 32'h0;
   logic i_reg_wr = 1'b0;
   logic i_reg_rd = 1'b0;
   logic [31:0] o_reg_rdata;
   legacy_address_decoder_pkg::request_s i_req = '0;
   legacy_address_decoder_pkg::forward_s o_fwd;
   legacy_address_decoder_pkg::host_reply_s o_host_reply;
   logic [31:0] taken, dram_taken, fwd_n, dram_n, term_n;
   logic [31:0] seed = 32'h12;
   logic [2:0] vctl = 3'h0;
   logic [25:0] attr = 26'h0;
   logic [1:0] last_t = 2'h0;
   logic [31:0] io_ofs = 32'hC3FA9854;
   int err_total = 0;
   int compares = 0;
   always #12.5 i_clock = ~i_clock;
   legacy_address_decoder u_dut (.i_clock(i_clock), .i_rst(i_rst), .i_clk_en(i_clk_en),
      .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
      .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .i_req(i_req), .o_fwd(o_fwd),
      .o_host_reply(o_host_reply));
   legacy_downstream_sink u_sink (.i_clock(i_clock), .i_rst(i_rst), .i_fwd(o_fwd),
      .o_taken(taken), .o_dram_taken(dram_taken));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic complete_run();
      if (err_total == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
      compares++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_wdata <= d;
      i_reg_wr <= 1'b1;
      @(posedge i_clock);
      i_reg_wr <= 1'b0;
      if (a == 4'h0)
         vctl = d[2:0];
      if (a == 4'h4)
         attr = d[25:0];
   endtask
   task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_clock);
      i_reg_addr <= a;
      i_reg_rd <= 1'b1;
      @(posedge i_clock);
      i_reg_rd <= 1'b0;
      @(negedge i_clock);
      d = o_reg_rdata;
   endtask
   task automatic send(input legacy_address_decoder_pkg::request_s r);
      logic [1:0] t;
      t = route_ref(r, vctl, attr);
      r.valid = 1'b1;
      r.wdata = {rnd(), rnd()};
      @(posedge i_clock);
      i_req <= r;
      @(posedge i_clock);
      i_req.valid <= 1'b0;
      last_t = t;
      @(negedge i_clock);
      chk("fwd_valid", t != 2'h2, o_fwd.valid);
      chk("reply_valid", t == 2'h2 && !r.is_write, o_host_reply.valid);
      if (t == 2'h2)
         term_n++;
      if (t == 2'h2 && !r.is_write)
         chk("reply_data", 64'h0, o_host_reply.data);
      if (t != 2'h2)
      begin
         fwd_n++;
         dram_n += {31'h0, t == 2'h0};
         chk("target", t, o_fwd.target);
         chk("fwd_addr", r.addr[31:0], o_fwd.addr);
         chk("fwd_write", r.is_write, o_fwd.is_write);
         chk("fwd_io", r.is_io, o_fwd.is_io);
         chk("fwd_wdata", r.wdata, o_fwd.wdata);
      end
   endtask
   initial
   begin
      legacy_address_decoder_pkg::request_s r;
      logic [31:0] d;
      logic [31:0] x;
      fwd_n = 32'h0;
      dram_n = 32'h0;
      term_n = 32'h0;
      repeat (20) @(posedge i_clock);
      i_rst <= 1'b0;
      reg_wr(4'hC, 32'hFFFFFFFF);
      reg_wr(4'h8, 32'hFFFFFFFF);
      for (int k = 0; k < 16; k += 4)
      begin
         reg_rd(4'(k), d);
         chk("reg_reset", 32'h0, d);
      end
      // a low clock enable must swallow a request and a register write alike
      r = '0;
      r.valid = 1'b1;
      r.addr = 36'h100000000;
      @(posedge i_clock);
      i_clk_en <= 1'b0;
      i_req <= r;
      i_reg_addr <= 4'h0;
      i_reg_wdata <= 32'h7;
      i_reg_wr <= 1'b1;
      @(posedge i_clock);
      i_clk_en <= 1'b1;
      i_req.valid <= 1'b0;
      i_reg_wr <= 1'b0;
      @(negedge i_clock);
      chk("frozen_reply", 64'h0, {63'h0, o_host_reply.valid});
      reg_rd(4'h0, d);
      chk("frozen_write", 32'h0, d);
      r = '0;
      r.addr = 36'hF0000;
      send(r);
      for (int s = 0; s < 13; s++)
         for (int st = 0; st < 4; st++)
         begin
            reg_wr(4'h4, st << (2 * s));
            for (int k = 0; k < 4; k++)
            begin
               r = '0;
               r.addr = 36'hC0000 + s * 36'h4000 + (k[0] ? (s == 12 ? 36'hFFFF : 36'h3FFF) : 0);
               r.is_write = k[1];
               send(r);
            end
         end
      for (int v = 0; v < 8; v++)
      begin
         reg_wr(4'h0, v);
         for (int k = 0; k < 24; k++)
         begin
            r = '0;
            r.addr = 36'hA0000 + {k[1:0], 15'h0} + (k[2] ? 36'h7FFF : 36'h0);
            r.smm = k[3];
            r.origin = legacy_address_decoder_pkg::origin_e'(rnd() % 32'h3);
            r.is_io = k > 15;
            // every mono port once, plus two neighbours that must stay on the hub
            if (k > 15)
               r.addr = 36'h3B0 + 36'(io_ofs[4 * k[2:0] +: 4]);
            send(r);
         end
      end
      for (int n = 0; n < 1500; n++)
      begin
         if (rnd() % 32'h10 == 32'h0)
            reg_wr(rnd() % 32'h2 == 32'h0 ? 4'h0 : 4'h4, rnd());
         x = rnd();
         d = rnd();
         r = '0;
         r.addr = {d[3:0], x};
         if (d[5:4] == 2'h0)
            r.addr[35:20] = 16'h0;
         if (d[5:4] == 2'h1)
            r.addr[35:32] = 4'h0;
         r.is_io = d[5:4] == 2'h3 && d[10];
         if (r.is_io)
            r.addr = 36'h3B0 + x[3:0];
         r.is_write = d[6];
         r.smm = d[7];
         r.origin = legacy_address_decoder_pkg::origin_e'(d[9:8] % 2'h3);
         send(r);
      end
      reg_rd(4'h8, d);
      chk("term_count", term_n[15:0], d[15:0]);
      chk("last_target", last_t, d[17:16]);
      chk("sink_taken", fwd_n, taken);
      chk("sink_dram", dram_n, dram_taken);
      complete_run();
   end
   initial
   begin
      #500000;
      err_total++;
      complete_run();
   end
endmodule // test_legacy_address_decoder
`default_nettype wire
